// ==== hw/gil_irq_addr.sv ====
// interrupt status/mask registers and own-address recognition
`timescale 1ns/1ps
module gil_irq_addr (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// host register port
	input  wire logic       ce_n,
	input  wire logic       we_n,
	input  wire logic       dbin,
	input  wire logic [2:0] rs,
	input  wire logic [7:0] d_in,
	output logic      [7:0] d_out,
	output logic            d_oe,
	output logic            int_pull_low,
	// feature settings from the auxiliary command decoder
	input  wire logic       swrst_hold,
	input  wire logic       dai_set,
	input  wire logic       shadow_on,
	input  wire logic       pts_set,
	input  wire logic       hold_all,
	input  wire logic       hold_end,
	input  wire logic       dacr_pulse,
	input  wire logic       dacr_cs,
	input  wire logic       rhdf_pulse,
	input  wire logic       sys_ctrl,
	// bus lines and interface-function states
	input  wire logic [7:0] bus_byte,
	input  wire logic       acc_cmd,
	input  wire logic       acc_data,
	input  wire logic       eoi_line,
	input  wire logic       atn_line,
	input  wire logic       srq_line,
	input  wire logic       ifc_line,
	input  wire logic       ndac_high,
	input  wire logic       nrfd_high,
	input  wire logic       src_active,
	input  wire logic       src_generate,
	input  wire logic       src_hold_idle,
	input  wire logic       ctrl_active,
	input  wire logic       ctrl_in_charge,
	input  wire logic       talker_active,
	input  wire logic       unsent_byte,
	input  wire logic       spoll_xfer,
	input  wire logic       service_req,
	input  wire logic       far_control_flag,
	input  wire logic       lockout_state,
	input  wire logic       lpas_in,
	input  wire logic       tpas_in,
	input  wire logic       lads_in,
	input  wire logic       tads_in,
	// controls back to the interface functions
	output logic            trigger_output,
	output logic            dac_holdoff,
	output logic            rfd_holdoff,
	output logic            apt_verdict,
	output logic            extended_mode,
	output logic            listen_off,
	output logic            talk_off
);
	import gil_pkg::*;

	logic [7:0] mask0_r;
	logic [7:0] mask1_r;
	logic [7:0] addr_r;
	logic [7:0] st_r    [2];
	logic [7:0] pend_r  [2];
	logic [7:0] cond    [2];
	logic [7:0] cond_r  [2];
	logic [7:0] ev      [2];
	logic [7:0] clr     [2];
	logic [1:0] rd_in;
	logic [1:0] rd_end;
	logic       rd_act;
	logic       rd_act_r;
	logic [2:0] rd_sel_r;
	logic       wr_act;
	logic       wr_act_r;
	logic       wr_start;
	logic       sum0;
	logic       sum1;
	logic       spoll_r;
	logic       remote_r;
	logic       ulpa_r;
	logic [7:0] trig_cnt_r;
	logic       trig_hold_r;
	logic [1:0] grp;
	logic [6:0] cmd;
	logic       addr_hit;
	logic       mla;
	logic       mta;
	logic       unk;

	////////////////////////////////////////////////////////////////////
	// host strobes
	assign rd_act   = ~ce_n & we_n & dbin;
	assign wr_act   = ~ce_n & ~we_n & ~dbin;
	assign wr_start = wr_act & ~wr_act_r;
	assign rd_in[0] = rd_act & (rs == RS_STATUS0);
	assign rd_in[1] = rd_act & (rs == RS_STATUS1);
	assign rd_end[0] = rd_act_r & ~rd_act & (rd_sel_r == RS_STATUS0);
	assign rd_end[1] = rd_act_r & ~rd_act & (rd_sel_r == RS_STATUS1);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_act_r <= 1'b0;
			wr_act_r <= 1'b0;
			rd_sel_r <= 3'h0;
		end else begin
			rd_act_r <= rd_act;
			wr_act_r <= wr_act;
			if (rd_act)
				rd_sel_r <= rs;
		end
	end

	// masks; address register has no reset so it survives both resets
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask0_r <= 8'h00;
			mask1_r <= 8'h00;
		end else if (wr_start && rs == WS_MASK0) begin
			mask0_r <= d_in & ST0_STORED;
		end else if (wr_start && rs == WS_MASK1) begin
			mask1_r <= d_in;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (wr_start && rs == WS_ADDRESS)
			addr_r <= d_in; // RULE_21
	end

	////////////////////////////////////////////////////////////////////
	// command decode and address comparator
	assign cmd = bus_byte[6:0];
	assign grp = bus_byte[6:5];
	// dual addressing drops the LSB from the compare
	assign addr_hit = (cmd[4:1] == addr_r[4:1]) &&
		(addr_r[AD_EDPA] || cmd[0] == addr_r[0]); // RULE_20
	assign mla = (grp == GRP_LISTEN) && addr_hit && !addr_r[AD_DAL];
	assign mta = (grp == GRP_TALK) && addr_hit && !addr_r[AD_DAT];
	assign unk = (grp == GRP_CMD) && (cmd[4] ?
		!(cmd == CMD_LLO || cmd == CMD_DCL ||
		  cmd == CMD_SPE || cmd == CMD_SPD) :
		(!(cmd == CMD_GET || cmd == CMD_GTL ||
		   cmd == CMD_SDC || cmd == CMD_TCT) && lads_in)) ||
		(cmd == CMD_TCT && tads_in) ||
		(grp == GRP_SEC && pts_set); // RULE_15

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			ulpa_r <= 1'b0;
		else if (acc_cmd && (mla || mta))
			ulpa_r <= cmd[0]; // RULE_20
	end

	////////////////////////////////////////////////////////////////////
	// qualifying conditions
	always_comb begin
		cond[0] = 8'h00;
		cond[1] = 8'h00;
		cond[0][B0_BI]   = acc_data & lads_in & ~shadow_on; // RULE_03
		cond[0][B0_BO]   = src_generate & ~unsent_byte &
			(ctrl_active | (talker_active & src_hold_idle)); // RULE_05
		cond[0][B0_END]  = cond[0][B0_BI] & eoi_line; // RULE_07
		cond[0][B0_POLL_STATUS_SENT] = spoll_r & ~spoll_xfer & service_req; // RULE_08
		cond[0][B0_RLC]  = far_control_flag ^ remote_r; // RULE_09
		cond[0][B0_MAC]  = acc_cmd & ~mask1_r[B1_APT] &
			((mta & ~tads_in) | (grp == GRP_TALK && !mta &&
			cmd != CMD_UNT && tads_in) | (mla & ~lads_in) |
			(cmd == CMD_UNL && lads_in)); // RULE_10
		cond[1][B1_GET]  = acc_cmd & (cmd == CMD_GET) & lads_in;
		cond[1][B1_ERR]  = src_active & ndac_high & nrfd_high; // RULE_14
		cond[1][B1_UNC]  = acc_cmd & unk; // RULE_15
		cond[1][B1_APT]  = acc_cmd & (grp == GRP_SEC) &
			(lpas_in | tpas_in); // RULE_16
		cond[1][B1_DCAS] = acc_cmd & ((cmd == CMD_DCL) |
			((cmd == CMD_SDC) & lads_in)); // RULE_17
		cond[1][B1_MA]   = acc_cmd & (mla | mta); // RULE_18
		cond[1][B1_SRQ]  = srq_line & ctrl_in_charge;
		cond[1][B1_IFC]  = ifc_line & ~sys_ctrl; // RULE_19
	end

	always_comb begin
		clr[0] = 8'h00;
		clr[1] = 8'h00;
		clr[0][B0_BI] = rd_end[0] ? 1'b0 :
			rd_act_r & ~rd_act & (rd_sel_r == RS_DATA_IN); // RULE_04
		clr[0][B0_BO] = wr_start & (rs == WS_DATA_OUT); // RULE_06
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			spoll_r  <= 1'b0;
			remote_r <= 1'b0;
		end else begin
			spoll_r  <= spoll_xfer;
			remote_r <= far_control_flag;
		end
	end

	////////////////////////////////////////////////////////////////////
	// status registers: edge set, clear at end of read
	for (genvar g = 0; g < 2; g++) begin : g_stat
		localparam logic [7:0] STORED = (g == 0) ? ST0_STORED : 8'hff;
		assign ev[g] = cond[g] & ~cond_r[g] & STORED; // RULE_26

		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n)
				cond_r[g] <= 8'h00;
			else
				cond_r[g] <= cond[g];
		end

		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				st_r[g]   <= 8'h00;
				pend_r[g] <= 8'h00;
			end else if (swrst_hold) begin
				st_r[g]   <= 8'h00; // RULE_26 RULE_11
				pend_r[g] <= 8'h00;
			end else if (rd_end[g]) begin
				st_r[g]   <= pend_r[g] | ev[g]; // RULE_25 RULE_04 RULE_06
				pend_r[g] <= 8'h00;
			end else if (rd_in[g]) begin
				pend_r[g] <= pend_r[g] | ev[g]; // RULE_25
			end else begin
				st_r[g]   <= (st_r[g] & ~clr[g]) | ev[g];
			end
		end
	end

	// mask bit one unmasks
	assign sum0 = |(st_r[0] & mask0_r & ST0_STORED); // RULE_02 RULE_24
	assign sum1 = |(st_r[1] & mask1_r); // RULE_01 RULE_24

	////////////////////////////////////////////////////////////////////
	// host read data and interrupt pin
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			d_out        <= 8'h00;
			d_oe         <= 1'b0;
			int_pull_low <= 1'b0;
		end else begin
			int_pull_low <= (sum0 | sum1) & ~dai_set; // RULE_23
			d_oe         <= rd_act && rs <= RS_ADDR_STAT;
			case (rs)
			RS_STATUS0: d_out <= {sum0, sum1, st_r[0][5:0]};
			RS_STATUS1: d_out <= st_r[1];
			RS_ADDR_STAT: d_out <= {far_control_flag, lockout_state,
				atn_line, lpas_in, tpas_in, lads_in, tads_in, ulpa_r};
			default: d_out <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// holdoffs, trigger, mode outputs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_holdoff <= 1'b0;
			rfd_holdoff <= 1'b0;
			apt_verdict <= 1'b0;
		end else if (swrst_hold) begin
			dac_holdoff <= 1'b0;
			rfd_holdoff <= 1'b0;
		end else begin
			if (|(ev[1] & mask1_r & DAC_GROUP))
				dac_holdoff <= 1'b1; // RULE_15 RULE_16 RULE_17 RULE_18
			else if (dacr_pulse)
				dac_holdoff <= 1'b0;
			if (dacr_pulse && st_r[1][B1_APT])
				apt_verdict <= dacr_cs; // RULE_16
			// holdoff comes regardless of the byte-in mask
			if ((ev[0][B0_BI] & hold_all) | (ev[0][B0_END] & hold_end))
				rfd_holdoff <= 1'b1; // RULE_03
			else if (rhdf_pulse)
				rfd_holdoff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_cnt_r     <= 8'h00;
			trig_hold_r    <= 1'b0;
			trigger_output <= 1'b0;
		end else begin
			if (ev[1][B1_GET]) begin
				trig_cnt_r  <= mask1_r[B1_GET] ? 8'h00 : TRIG_PULSE_CYC;
				trig_hold_r <= mask1_r[B1_GET]; // RULE_13
			end else begin
				if (trig_cnt_r != 8'h00)
					trig_cnt_r <= trig_cnt_r - 8'h01;
				if (!dac_holdoff)
					trig_hold_r <= 1'b0;
			end
			trigger_output <= ev[1][B1_GET] | (trig_cnt_r > 8'h01) |
				(trig_hold_r & dac_holdoff); // RULE_13
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			extended_mode <= 1'b0;
			listen_off    <= 1'b0;
			talk_off      <= 1'b0;
		end else begin
			extended_mode <= mask1_r[B1_APT]; // RULE_12
			listen_off    <= addr_r[AD_DAL];
			talk_off      <= addr_r[AD_DAT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n || swrst_hold);

	sequence s_evt_in_read;
		rd_in[1] && ev[1] != 8'h00 ##1 !rd_act;
	endsequence

	int_pin_low_a: assert property (sum1 && !dai_set |=> int_pull_low) // RULE_23
		else $error("interrupt pin not pulled low");
	read_keep_a: assert property (s_evt_in_read |=> st_r[1] != 8'h00) // RULE_25
		else $error("event during status read lost");
	bi_set_a: assert property (ev[0][B0_BI] && !rd_in[0] |=> st_r[0][B0_BI]) // RULE_03
		else $error("byte-received flag not set");
	shadow_bi_a: assert property (shadow_on && !pend_r[0][B0_BI]
		|=> !$rose(st_r[0][B0_BI])) // RULE_03
		else $error("byte-received set while shadowing");
	end_pair_a: assert property ($rose(st_r[0][B0_END]) |-> st_r[0][B0_BI]) // RULE_07
		else $error("end flag without byte-received");
	bo_clear_a: assert property (clr[0][B0_BO] && !ev[0][B0_BO] && !rd_in[0]
		|=> !st_r[0][B0_BO]) // RULE_06
		else $error("byte-output-ready not cleared by write");
	trig_pulse_a: assert property (ev[1][B1_GET] && !mask1_r[B1_GET]
		|=> trigger_output [*5] ##1 !trigger_output) // RULE_13
		else $error("trigger pulse length wrong");
	ma_hold_a: assert property (ev[1][B1_MA] && mask1_r[B1_MA]
		|=> dac_holdoff) // RULE_18
		else $error("no holdoff after own-address match");
	ifc_sys_a: assert property (sys_ctrl && !pend_r[1][B1_IFC]
		|=> !$rose(st_r[1][B1_IFC])) // RULE_19
		else $error("interface-clear flag set in system controller");
	swrst_zero_a: assert property (disable iff (!rst_n)
		swrst_hold |=> st_r[0] == 8'h00 && st_r[1] == 8'h00) // RULE_11
		else $error("status not held at zero by software reset");
endmodule

// ==== hw/gil_pkg.sv ====
// constants for the interrupt, mask and address-recognition logic
// Functional notes
// [RULE_01] second summary: any unmasked set status-one bit
// [RULE_02] first summary: unmasked set bits two to seven
// [RULE_03] byte-received sets on accept, never while shadowing
// [RULE_04] byte-received clears on data-in or status read
// [RULE_05] byte-output-ready sets on generate state, no pending byte
// [RULE_06] byte-output-ready clears on data-out write, status read
// [RULE_07] end flag sets with byte-received when EOI
// [RULE_08] poll-sent flag on falling poll transfer state
// [RULE_09] remote/local change flag on every transition
// [RULE_10] address change flag, not in extended addressing
// [RULE_11] status-one bits stored, cleared by read or reset
// [RULE_12] secondary mask selects extended talker and listener
// [RULE_13] GET raises trigger; holds or pulses by mask
// [RULE_14] error flag when no acceptors found
// [RULE_15] unknown-command flag with addressed qualifications
// [RULE_16] secondary pass-through flag, host releases with verdict
// [RULE_17] device-clear flag on DCL or addressed SDC
// [RULE_18] own-address match flag, holdoff when unmasked
// [RULE_19] interface-clear flag unless system controller
// [RULE_20] dual addressing ignores address LSB, reports it
// [RULE_21] address register survives every reset
// [RULE_22] host never loads all-ones primary address
// [RULE_23] interrupt pin low on summary unless disabled
// [RULE_24] mask zero masks, mask one unmasks
// [RULE_25] event during status read set after read
// [RULE_26] status sets on rising condition, swrst holds zero
package gil_pkg;
	localparam logic [7:0] TRIG_PULSE_CYC = 8'h05;
	// register selects
	localparam logic [2:0] RS_STATUS0   = 3'h0;
	localparam logic [2:0] RS_STATUS1   = 3'h1;
	localparam logic [2:0] RS_ADDR_STAT = 3'h2;
	localparam logic [2:0] RS_DATA_IN   = 3'h7;
	localparam logic [2:0] WS_MASK0     = 3'h0;
	localparam logic [2:0] WS_MASK1     = 3'h1;
	localparam logic [2:0] WS_ADDRESS   = 3'h4;
	localparam logic [2:0] WS_DATA_OUT  = 3'h7;
	// status 0 bit positions (bus line D0 is bit 7)
	localparam int B0_SUM0 = 7;
	localparam int B0_SUM1 = 6;
	localparam int B0_BI   = 5;
	localparam int B0_BO   = 4;
	localparam int B0_END  = 3;
	localparam int B0_POLL_STATUS_SENT = 2;
	localparam int B0_RLC  = 1;
	localparam int B0_MAC  = 0;
	// status 1 bit positions
	localparam int B1_GET  = 7;
	localparam int B1_ERR  = 6;
	localparam int B1_UNC  = 5;
	localparam int B1_APT  = 4;
	localparam int B1_DCAS = 3;
	localparam int B1_MA   = 2;
	localparam int B1_SRQ  = 1;
	localparam int B1_IFC  = 0;
	localparam logic [7:0] ST0_STORED = 8'h3f;
	localparam logic [7:0] DAC_GROUP  = 8'hbc;
	// address register fields
	localparam int AD_EDPA = 7;
	localparam int AD_DAL  = 6;
	localparam int AD_DAT  = 5;
	// bus commands, seven bits
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_TCT = 7'h09;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3f;
	localparam logic [6:0] CMD_UNT = 7'h5f;
	localparam logic [1:0] GRP_CMD    = 2'h0;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK   = 2'h2;
	localparam logic [1:0] GRP_SEC    = 2'h3;
endpackage

// ==== verification/gil_far_model.sv ====
// host port and accepted-byte model facing the interrupt block
`timescale 1ns/1ps
module gil_far_model (
	// clock
	input  wire logic       ref_clk,
	// host register port
	output logic            ce_n,
	output logic            we_n,
	output logic            dbin,
	output logic      [2:0] rs,
	output logic      [7:0] d_in,
	input  wire logic [7:0] d_out,
	// accepted bus bytes
	output logic      [7:0] bus_byte,
	output logic            acc_cmd,
	output logic            acc_data,
	output logic            eoi_line
);
	import gil_pkg::*;
	logic [7:0] rd_val;
	initial begin
		{ce_n, we_n, dbin, rs, d_in} = {3'b110, 3'h0, 8'h5a};
		{bus_byte, acc_cmd, acc_data, eoi_line} = {8'ha5, 3'h0};
	end
	////////////////////////////////////////////////////////////////////////
	// write taken at the first edge; data scrambled once released
	task automatic wr(input logic [2:0] sel, input logic [7:0] val);
		@(negedge ref_clk);
		{ce_n, we_n, rs, d_in} = {2'b00, sel, val};
		@(negedge ref_clk);
		{ce_n, we_n, d_in} = {2'b11, ~val};
		@(negedge ref_clk);
	endtask
	task automatic rd(input logic [2:0] sel);
		@(negedge ref_clk);
		{ce_n, dbin, rs} = {2'b01, sel};
		repeat (2) @(negedge ref_clk);
		rd_val = d_out;
		{ce_n, dbin} = 2'b10;
		repeat (2) @(negedge ref_clk);
	endtask
	// accepted byte; lines hold no stale value afterwards
	task automatic take(input logic c, input logic [7:0] b, input logic e);
		@(negedge ref_clk);
		{bus_byte, eoi_line, acc_cmd, acc_data} = {b, e, c, !c};
		repeat (2) @(negedge ref_clk);
		{bus_byte, eoi_line, acc_cmd, acc_data} = {~b, 3'h0};
		repeat (2) @(negedge ref_clk);
	endtask
endmodule

// ==== verification/gil_irq_addr_test.sv ====
// self-checking bench for the interrupt and address logic
`timescale 1ns/1ps
module gil_irq_addr_test;
	import gil_pkg::*;
	logic       ref_clk, rst_n, swrst_hold, dai_set, shadow_on, pts_set;
	logic       hold_all, hold_end, dacr_pulse, dacr_cs, rhdf_pulse;
	logic       sys_ctrl, atn_line, srq_line, ifc_line, ndac_high;
	logic       nrfd_high, src_active, src_generate, src_hold_idle;
	logic       ctrl_active, ctrl_in_charge, talker_active, unsent_byte;
	logic       spoll_xfer, service_req, far_control_flag, lockout_state;
	logic       lpas_in, tpas_in, lads_in, tads_in, ce_n, we_n, dbin;
	logic       acc_cmd, acc_data, eoi_line, d_oe, int_pull_low;
	logic       trigger_output, dac_holdoff, rfd_holdoff, apt_verdict;
	logic       extended_mode, listen_off, talk_off;
	logic [2:0] rs;
	logic [7:0] d_in, d_out, bus_byte;
	logic [31:0] seed = 32'd91;
	int         num_errors, n_checks, ex0, ex1, m0, m1, cyc;
	gil_irq_addr DUT (.ref_clk, .rst_n, .ce_n, .we_n, .dbin, .rs, .d_in,
		.d_out, .d_oe, .int_pull_low, .swrst_hold, .dai_set, .shadow_on,
		.pts_set, .hold_all, .hold_end, .dacr_pulse, .dacr_cs, .rhdf_pulse,
		.sys_ctrl, .bus_byte, .acc_cmd, .acc_data, .eoi_line, .atn_line,
		.srq_line, .ifc_line, .ndac_high, .nrfd_high, .src_active,
		.src_generate, .src_hold_idle, .ctrl_active, .ctrl_in_charge,
		.talker_active, .unsent_byte, .spoll_xfer, .service_req,
		.far_control_flag, .lockout_state, .lpas_in, .tpas_in, .lads_in,
		.tads_in, .trigger_output, .dac_holdoff, .rfd_holdoff, .apt_verdict,
		.extended_mode, .listen_off, .talk_off);
	gil_far_model far (.ref_clk, .ce_n, .we_n, .dbin, .rs, .d_in, .d_out,
		.bus_byte, .acc_cmd, .acc_data, .eoi_line);
	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 0;
		forever #2.5 ref_clk = !ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] sum0();
		logic [7:0] e;
		e = 8'(ex0) & ST0_STORED;
		e[B0_SUM0] = (ex0 & m0 & 'h3f) != 0;
		e[B0_SUM1] = (ex1 & m1) != 0;
		return e;
	endfunction
	task automatic chk8(input string s, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk1(input string s, input logic e, g);
		chk8(s, {7'h0, e}, {7'h0, g});
	endtask
	// read a status register and apply the read-clear to the model
	task automatic st(input logic [2:0] sel);
		logic [7:0] e;
		e = sel == RS_STATUS0 ? sum0() : 8'(ex1);
		fork
			far.rd(sel);
			begin
				repeat (2) @(negedge ref_clk);
				chk1("oe", 1, d_oe);
			end
		join
		chk8(sel == RS_STATUS0 ? "status0" : "status1", e, far.rd_val);
		if (sel == RS_STATUS0) ex0 = 0;
		else ex1 = 0;
	endtask
	task automatic mask(input logic one, input logic [7:0] v);
		far.wr(one ? WS_MASK1 : WS_MASK0, v);
		if (one) m1 = v;
		else m0 = v;
	endtask
	task automatic tog(ref logic s);
		s = !s;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, swrst_hold, dai_set, shadow_on, pts_set, hold_all, hold_end,
			dacr_pulse, dacr_cs, rhdf_pulse, sys_ctrl, atn_line, srq_line,
			ifc_line, ndac_high, nrfd_high, src_active, src_generate,
			src_hold_idle, ctrl_active, ctrl_in_charge, talker_active,
			unsent_byte, spoll_xfer, service_req, far_control_flag,
			lockout_state, lpas_in, tpas_in, lads_in, tads_in} = 31'h20000000;
		repeat (20) @(negedge ref_clk);
		rst_n = 1;
		far.wr(WS_ADDRESS, 8'h05);
		far.take(1, 8'h25, 0);
		st(RS_STATUS1);
		rst_n = 0;
		repeat (2) @(negedge ref_clk);
		{rst_n, swrst_hold} = 2'b10;
		far.take(1, 8'h25, 0);
		ex1 = 1 << B1_MA;
		ex0 = 1 << B0_MAC;
		st(RS_STATUS1);
		st(RS_STATUS0);
		st(RS_STATUS1);
		done("address");
		mask(1, 8'(1 << B1_MA));
		far.take(1, 8'h25, 0);
		ex1 = 1 << B1_MA;
		ex0 = 1 << B0_MAC;
		chk1("int", 1, int_pull_low);
		chk1("dac", 1, dac_holdoff);
		dai_set = 1;
		repeat (3) @(negedge ref_clk);
		chk1("int", 0, int_pull_low);
		dai_set = 0;
		tog(dacr_pulse);
		tog(dacr_pulse);
		chk1("dac", 0, dac_holdoff);
		st(RS_STATUS0);
		st(RS_STATUS1);
		mask(1, 8'h00);
		swrst_hold = 1;
		far.wr(WS_ADDRESS, 8'h85);
		swrst_hold = 0;
		for (int i = 0; i < 2; i++) begin
			far.take(1, 8'h24 | 8'(i), 0);
			far.rd(RS_ADDR_STAT);
			chk8("addr_stat", 8'(i), far.rd_val);
		end
		ex1 = 1 << B1_MA;
		ex0 = 1 << B0_MAC;
		st(RS_STATUS1);
		st(RS_STATUS0);
		done("mask");
		{lads_in, hold_all} = 2'b11;
		far.take(0, 8'h41, 1);
		ex0 = 1 << B0_BI | 1 << B0_END;
		chk1("rfd", 1, rfd_holdoff);
		tog(rhdf_pulse);
		tog(rhdf_pulse);
		chk1("rfd", 0, rfd_holdoff);
		hold_all = 0;
		far.rd(RS_DATA_IN);
		ex0 = 1 << B0_END;
		st(RS_STATUS0);
		shadow_on = 1;
		far.take(0, 8'h42, 0);
		shadow_on = 0;
		st(RS_STATUS0);
		far.take(1, {1'b0, CMD_GET}, 0);
		chk1("trig", 1, trigger_output);
		repeat (int'(TRIG_PULSE_CYC) + 8) @(negedge ref_clk);
		chk1("trig", 0, trigger_output);
		far.take(1, 8'h07, 0);
		far.take(1, {1'b0, CMD_DCL}, 0);
		ex1 = 1 << B1_GET | 1 << B1_UNC | 1 << B1_DCAS;
		st(RS_STATUS1);
		mask(1, 8'(1 << B1_GET));
		far.take(1, {1'b0, CMD_GET}, 0);
		repeat (250) @(negedge ref_clk);
		chk1("trig", 1, trigger_output);
		tog(dacr_pulse);
		tog(dacr_pulse);
		chk1("trig", 0, trigger_output);
		ex1 = 1 << B1_GET;
		st(RS_STATUS1);
		mask(1, 8'(1 << B1_APT));
		chk1("ext", 1, extended_mode);
		lpas_in = 1;
		far.take(1, 8'h60, 0);
		chk1("dac", 1, dac_holdoff);
		dacr_cs = 1;
		tog(dacr_pulse);
		tog(dacr_pulse);
		chk1("apt", 1, apt_verdict);
		chk1("dac", 0, dac_holdoff);
		{lpas_in, dacr_cs} = 2'b00;
		ex1 = 1 << B1_APT;
		st(RS_STATUS1);
		mask(1, 8'h00);
		done("listen");
		{ndac_high, nrfd_high, service_req, lockout_state} = 4'hf;
		tog(src_active);
		tog(ifc_line);
		tog(ifc_line);
		tog(spoll_xfer);
		tog(spoll_xfer);
		tog(far_control_flag);
		ex1 = 1 << B1_ERR | 1 << B1_IFC;
		ex0 = 1 << B0_POLL_STATUS_SENT | 1 << B0_RLC;
		st(RS_STATUS0);
		st(RS_STATUS1);
		sys_ctrl = 1;
		tog(ifc_line);
		st(RS_STATUS1);
		{talker_active, src_hold_idle} = 2'b11;
		tog(src_generate);
		ex0 = 1 << B0_BO;
		st(RS_STATUS0);
		tog(src_generate);
		tog(src_generate);
		far.wr(WS_DATA_OUT, 8'h33);
		unsent_byte = 1;
		tog(src_generate);
		tog(src_generate);
		st(RS_STATUS0);
		swrst_hold = 1;
		far.wr(WS_ADDRESS, 8'h65);
		swrst_hold = 0;
		chk1("loff", 1, listen_off);
		chk1("toff", 1, talk_off);
		far.take(1, 8'h25, 0);
		far.take(1, 8'h45, 0);
		st(RS_STATUS1);
		done("lines");
		for (int i = 0; i < 4; i++) begin
			mask(0, 8'(xs()) & 8'h3f);
			far.take(0, 8'(xs()), 0);
			ex0 = 1 << B0_BI;
			chk1("int", (sum0() & 8'hc0) != 0, int_pull_low);
			st(RS_STATUS0);
		end
		done("random");
		tally_and_finish();
	end
endmodule
